// File: dv/pin_partner.sv
`timescale 1ns/1ps

// Far side of the pins: external drivers, the weak pulls and a floating wire.
module pin_partner
    import pin_cfg_pkg::*;
(
    input  wire logic            i_mclk,
    input  wire logic [NPIN-1:0] i_out,
    input  wire logic [NPIN-1:0] i_oe,
    input  wire logic [NPIN-1:0] i_pu,
    input  wire logic [NPIN-1:0] i_pd,
    input  wire logic [NGP-1:0]  i_ext_en,
    input  wire logic [NGP-1:0]  i_ext_val,
    output logic      [NGP-1:0]  o_lvl
);
    logic [NGP-1:0] float_ff = '0;

    // An undriven wire keeps changing so a stale value cannot pass for a level.
    always @(posedge i_mclk) begin
        float_ff <= ~float_ff;
    end

    always_comb begin
        for (int i = 0; i < NGP; i++) begin
            if (i_oe[i]) begin
                o_lvl[i] = i_out[i];
            end else if (i_ext_en[i]) begin
                o_lvl[i] = i_ext_val[i];
            end else if (i_pu[i]) begin
                o_lvl[i] = 1'b1;
            end else if (i_pd[i]) begin
                o_lvl[i] = 1'b0;
            end else begin
                o_lvl[i] = float_ff[i];
            end
        end
    end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps

`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin \
    miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, s); end end

module tb
    import pin_cfg_pkg::*;
;
    localparam int TC = 8;
    logic            mclk = 1'b0;
    logic            resetn;
    logic            ce;
    logic [7:0]      addr;
    logic [31:0]     wdata;
    logic            wr;
    logic            rd;
    logic [31:0]     rdata;
    logic            otp_valid;
    cfg_t            otp_cfg;
    usb_state_t      usb;
    uart_side_t      uart;
    logic [NGP-1:0]  pin_in;
    logic [NPIN-1:0] pout;
    logic [NPIN-1:0] poe;
    logic [NPIN-1:0] pull_up;
    logic [NPIN-1:0] pull_dn;
    logic            cd_n;
    logic            cts_n;
    logic [NGP-1:0]  ext_en;
    logic [NGP-1:0]  ext_val;
    int              miscompares = 0;
    int              total_checks = 0;
    int              cycles = 0;
    logic [31:0]     seed = 32'h0000ABB8;

    always #50 mclk = ~mclk;

    pin_cfg #(.TCYC(TC)) pin_cfg_inst (
        .i_mclk(mclk), .i_resetn(resetn), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_otp_valid(otp_valid), .i_otp_cfg(otp_cfg), .i_usb(usb),
        .i_uart(uart), .i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe),
        .o_pull_up(pull_up), .o_pull_dn(pull_dn), .o_cd_n(cd_n),
        .o_cts_n(cts_n));

    pin_partner pin_partner_inst (
        .i_mclk(mclk), .i_out(pout), .i_oe(poe), .i_pu(pull_up),
        .i_pd(pull_dn), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_lvl(pin_in));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The ceiling sits well above the few hundred cycles the run needs.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic lvl(input logic [3:0] s, input usb_state_t u);
        logic pw;
        logic hit;
        pw = (u.max_power > POWER_LIMIT) ? (u.suspend | ~u.configured)
            : u.suspend;
        hit = (s[0] & u.bus_reset) | (s[1] & u.suspend) | (s[2] & pw);
        return s[3] ? hit : ~hit;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic tog(input int n, output int a, output int b);
        logic [NPIN-1:0] p;
        a = 0;
        b = 0;
        p = pout;
        repeat (n) begin
            tick(1);
            a += int'(pout[PIN_RXT] !== p[PIN_RXT]);
            b += int'(pout[PIN_TXT] !== p[PIN_TXT]);
            p = pout;
        end
    endtask

    initial begin
        logic [31:0] v;
        logic [31:0] r;
        logic [1:0]  od;
        logic        la;
        logic        lb;
        int          ta;
        int          tb_n;
        cfg_t        oc;
        usb_state_t  u;
        resetn = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        otp_valid = 1'b0;
        otp_cfg = CFG_DEF;
        usb = '0;
        uart = 4'h8;
        ext_en = '0;
        ext_val = '0;
        repeat (10) @(posedge mclk);
        `CHK("pull_up", 8'h22, pull_up)
        `CHK("cts_n", 1'b1, cts_n)
        resetn <= 1'b1;
        tick(3);
        `CHK("cts_n", 1'b1, cts_n)
        for (int i = 0; i < 2; i++) begin
            uart.de <= i[0];
            uart.rts_n <= i[0];
            tick(2);
            `CHK("hd", {i[0], 1'b1}, {pout[PIN_HD], poe[PIN_HD]})
            `CHK("rts oe", ~i[0], poe[PIN_RTS])
            `CHK("rts out", 1'b0, pout[PIN_RTS] & poe[PIN_RTS])
        end
        wrt(A_FUNC, 32'h5F);
        uart.de <= 1'b0;
        tick(2);
        `CHK("rts485 oe", 1'b1, poe[PIN_RTS])
        ext_en <= 6'h22;
        tick(8);
        `CHK("cts_n", 1'b0, cts_n)
        `CHK("cd_n", 1'b1, cd_n)
        rdr(A_GPIN, v);
        `CHK("gpin", 2'b00, {v[PIN_CD], v[PIN_CTS]})
        wrt(A_FUNC, 32'h3F);
        tick(8);
        `CHK("cd_n", 1'b0, cd_n)
        wrt(A_FUNC, 32'h3D);
        tick(8);
        `CHK("cts_n", 1'b1, cts_n)
        ext_en <= '0;
        wrt(A_PU, 32'hFF);
        tick(2);
        `CHK("pull_up", 8'hFF, pull_up)
        wrt(A_PD, 32'h14);
        tick(2);
        `CHK("pull_dn", 8'h14, pull_dn)
        usb.suspend <= 1'b1;
        tick(3);
        `CHK("pull_up", 8'hFF, pull_up)
        usb.bus_reset <= 1'b1;
        tick(2);
        `CHK("pulls", 16'h0, {pull_up, pull_dn})
        usb.bus_reset <= 1'b0;
        tick(2);
        `CHK("pulls", 16'h2200, {pull_up, pull_dn})
        rdr(A_FUNC, v);
        `CHK("func", 32'h1F, v)
        `CHK("stat oe", 2'b10, poe[PIN_STB:PIN_STA])
        usb.suspend <= 1'b0;
        tog(20, ta, tb_n);
        `CHK("rx idle", 0, ta)
        `CHK("tx idle", 0, tb_n)
        uart.rx_active <= 1'b1;
        uart.tx_active <= 1'b1;
        tog(60, ta, tb_n);
        `CHK("rx toggles", 60 / TC, ta)
        `CHK("tx toggles", 60 / TC, tb_n)
        ce <= 1'b0;
        tog(20, ta, tb_n);
        `CHK("rx frozen", 0, ta)
        ce <= 1'b1;
        uart.rx_active <= 1'b0;
        uart.tx_active <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            r = xs();
            od = r[9:8];
            u = '0;
            u.suspend = r[10];
            u.configured = r[11];
            u.max_power = r[13] ? r[23:16] : (r[12] ? 8'h32 : 8'h33);
            wrt(A_STAT, {24'h0, r[7:0]});
            wrt(A_OD, {24'h0, od, 6'h01});
            usb <= u;
            tick(2);
            la = lvl(r[3:0], u);
            lb = lvl(r[7:4], u);
            `CHK("a oe", od[0] ? ~la : 1'b1, poe[PIN_STA])
            `CHK("a out", la & ~od[0], pout[PIN_STA] & poe[PIN_STA])
            `CHK("b oe", od[1] ? ~lb : 1'b1, poe[PIN_STB])
            `CHK("b out", lb & ~od[1], pout[PIN_STB] & poe[PIN_STB])
        end
        oc = CFG_DEF;
        oc.pu = 8'h0F;
        resetn <= 1'b0;
        otp_valid <= 1'b1;
        otp_cfg <= oc;
        usb <= '0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        tick(3);
        `CHK("otp pull_up", 8'h0F, pull_up)
        otp_cfg <= CFG_DEF;
        wrt(A_PU, 32'h55);
        usb.bus_reset <= 1'b1;
        tick(2);
        usb.bus_reset <= 1'b0;
        tick(2);
        `CHK("otp pull_up", 8'h0F, pull_up)
        wrap_up();
    end
endmodule

// File: src/pin_cfg.sv
`timescale 1ns/1ps

// What this block does
// (R1) Carrier pin: GPIO input pulled up, else carrier
// (R2) Status B: same conditions, default low suspend
// (R3) Receive indicator toggles about 10 Hz while receiving
// (R4) Transmit indicator toggles about 10 Hz while sending
// (R5) Half-duplex pin defaults to high direction enable
// (R6) Clear-to-send pin defaults to pulled-up input
// (R7) Request pin: GPIO, request or direction, open-drain
// (R8) Pin type set by register or OTP
// (R9) Pulls stay enabled during suspend
// (R10) OTP setting applies from next power-up
// (R11) Bus reset disables pulls until released
// (R12) Bus reset or power-up drops register settings
// (R13) Open-drain pins drive only low
// (R14) Power condition depends on max power threshold
// (R15) Idle indicators hold a steady level
module pin_cfg
    import pin_cfg_pkg::*;
#(
    parameter int TCYC = TOGGLE_CYC
) (
    input  wire logic            i_mclk,
    input  wire logic            i_resetn,
    input  wire logic            i_ce,
    input  wire logic [7:0]      i_addr,
    input  wire logic [31:0]     i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [31:0]     o_rdata,
    input  wire logic            i_otp_valid,
    input  wire cfg_t            i_otp_cfg,
    input  wire usb_state_t      i_usb,
    input  wire uart_side_t      i_uart,
    input  wire logic [NGP-1:0]  i_pin_in,
    output logic      [NPIN-1:0] o_pin_out,
    output logic      [NPIN-1:0] o_pin_oe,
    output logic      [NPIN-1:0] o_pull_up,
    output logic      [NPIN-1:0] o_pull_dn,
    output logic                 o_cd_n,
    output logic                 o_cts_n
);

    if (TCYC < 2 || TCYC > (2 ** CNT_W)) begin : g_chk
        $error("TCYC out of range for the indicator counter.");
    end

    typedef struct packed {
        cfg_t            cfg;
        cfg_t            base;
        logic            otp_done;
        logic [NGP-1:0]  s1;
        logic [NGP-1:0]  s2;
        logic [NGP-1:0]  s3;
        logic [NGP-1:0]  pin_in;
        logic            ind_rx;
        logic            ind_tx;
        logic [CNT_W-1:0] cnt_rx;
        logic [CNT_W-1:0] cnt_tx;
        logic            lvl_a;
        logic            lvl_b;
        logic [NPIN-1:0] pin_out;
        logic [NPIN-1:0] pin_oe;
        logic [NPIN-1:0] pull_up;
        logic [NPIN-1:0] pull_dn;
        logic            cd_n;
        logic            cts_n;
        logic [31:0]     rdata;
    } state_t;

    localparam state_t ST_RST = '{
        cfg:     CFG_DEF,
        base:    CFG_DEF,
        ind_rx:  1'b1,
        ind_tx:  1'b1,
        // Synchroniser starts at the pulled-up idle level, so the modem
        // inputs do not falsely assert for a few cycles after reset.
        s1:      CFG_DEF.pu[NGP-1:0],
        s2:      CFG_DEF.pu[NGP-1:0],
        s3:      CFG_DEF.pu[NGP-1:0],
        pin_in:  CFG_DEF.pu[NGP-1:0],
        pull_up: CFG_DEF.pu,
        pull_dn: CFG_DEF.pd,
        cd_n:    1'b1,
        cts_n:   1'b1,
        default: '0
    };

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TCYC - 1);

    state_t          st;
    state_t          nxt;
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] drv;

    // Open-drain pins never drive high; the weak pull-up gives the high.
    function automatic logic [1:0] drive(input logic l, input logic d,
                                         input logic od);
        if (od) begin
            drive = {d & ~l, 1'b0};
        end else begin
            drive = {d, l};
        end
    endfunction

    // Idle holds high; active toggles every TCYC cycles.
    function automatic logic [CNT_W:0] blink(input logic act,
                                             input logic l,
                                             input logic [CNT_W-1:0] c);
        if (!act) begin
            blink = {1'b1, {CNT_W{1'b0}}};
        end else if (c == CNT_LAST) begin
            blink = {~l, {CNT_W{1'b0}}};
        end else begin
            blink = {l, c + 1'b1};
        end
    endfunction

    function automatic logic stat_level(input logic [3:0] sel,
                                        input usb_state_t u);
        logic pwr;
        logic hit;
        if (u.max_power > POWER_LIMIT) begin
            pwr = u.suspend | ~u.configured;
        end else begin
            pwr = u.suspend;
        end
        hit = (sel[SC_RST] & u.bus_reset) | (sel[SC_SUSP] & u.suspend)
            | (sel[SC_PWR] & pwr);
        stat_level = sel[SC_POL] ? hit : ~hit;
    endfunction

    always_comb begin
        nxt = st;
        lvl = '0;
        drv = '0;
        nxt.s1 = i_pin_in;
        nxt.s2 = st.s1;
        nxt.s3 = st.s2;
        if (st.s2 == st.s3) begin
            nxt.pin_in = st.s3;
        end
        // OTP is sampled once after power-up only, so later OTP writes wait.
        if (!st.otp_done) begin
            nxt.otp_done = 1'b1;  // R10
            if (i_otp_valid) begin
                nxt.base = i_otp_cfg;  // R10
                nxt.cfg = i_otp_cfg;  // R8
            end
        end else if (i_usb.bus_reset) begin
            nxt.cfg = st.base;  // R12
        end else if (i_wr) begin
            unique case (i_addr)
                A_FUNC: begin
                    nxt.cfg.func = i_wdata[NGP-1:0];  // R7
                    nxt.cfg.rts485 = i_wdata[NGP];  // R7
                end
                A_DIR: nxt.cfg.dir = i_wdata[NGP-1:0];
                A_DOUT: nxt.cfg.dout = i_wdata[NGP-1:0];
                A_OD: nxt.cfg.od = i_wdata[NPIN-1:0];  // R8
                A_PU: nxt.cfg.pu = i_wdata[NPIN-1:0];  // R8
                A_PD: nxt.cfg.pd = i_wdata[NPIN-1:0];  // R8
                A_STAT: begin
                    nxt.cfg.stat_a = i_wdata[3:0];
                    nxt.cfg.stat_b = i_wdata[7:4];  // R2
                end
                default: ;
            endcase
        end

        {nxt.ind_rx, nxt.cnt_rx} = blink(i_uart.rx_active, st.ind_rx,
                                         st.cnt_rx);  // R3 R15
        {nxt.ind_tx, nxt.cnt_tx} = blink(i_uart.tx_active, st.ind_tx,
                                         st.cnt_tx);  // R4 R15
        nxt.lvl_a = stat_level(st.cfg.stat_a, i_usb);  // R14
        nxt.lvl_b = stat_level(st.cfg.stat_b, i_usb);  // R2 R14

        lvl[NGP-1:0] = st.cfg.dout;
        drv[NGP-1:0] = st.cfg.dir;
        if (st.cfg.func[PIN_RTS]) begin
            lvl[PIN_RTS] = st.cfg.rts485 ? i_uart.de : i_uart.rts_n;  // R7
            drv[PIN_RTS] = 1'b1;
        end
        if (st.cfg.func[PIN_CTS]) begin
            drv[PIN_CTS] = 1'b0;  // R6
        end
        if (st.cfg.func[PIN_HD]) begin
            lvl[PIN_HD] = i_uart.de;  // R5
            drv[PIN_HD] = 1'b1;
        end
        if (st.cfg.func[PIN_TXT]) begin
            lvl[PIN_TXT] = nxt.ind_tx;  // R4
            drv[PIN_TXT] = 1'b1;
        end
        if (st.cfg.func[PIN_RXT]) begin
            lvl[PIN_RXT] = nxt.ind_rx;  // R3
            drv[PIN_RXT] = 1'b1;
        end
        if (st.cfg.func[PIN_CD]) begin
            drv[PIN_CD] = 1'b0;  // R1
        end
        lvl[PIN_STA] = nxt.lvl_a;
        drv[PIN_STA] = 1'b1;
        lvl[PIN_STB] = nxt.lvl_b;  // R2
        drv[PIN_STB] = 1'b1;
        for (int i = 0; i < NPIN; i++) begin
            {nxt.pin_oe[i], nxt.pin_out[i]} =
                drive(lvl[i], drv[i], st.cfg.od[i]);  // R13
        end

        // Suspend is deliberately not a term here: pulls must hold.
        if (i_usb.bus_reset) begin
            nxt.pull_up = '0;  // R11
            nxt.pull_dn = '0;  // R11
        end else begin
            nxt.pull_up = st.cfg.pu;  // R9
            nxt.pull_dn = st.cfg.pd;  // R9
        end
        nxt.cd_n = st.cfg.func[PIN_CD] ? st.pin_in[PIN_CD] : 1'b1;  // R1
        nxt.cts_n = st.cfg.func[PIN_CTS] ? st.pin_in[PIN_CTS] : 1'b1;  // R6

        nxt.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                A_FUNC: nxt.rdata[NGP:0] = {st.cfg.rts485, st.cfg.func};
                A_DIR: nxt.rdata[NGP-1:0] = st.cfg.dir;
                A_DOUT: nxt.rdata[NGP-1:0] = st.cfg.dout;
                A_OD: nxt.rdata[NPIN-1:0] = st.cfg.od;
                A_PU: nxt.rdata[NPIN-1:0] = st.cfg.pu;
                A_PD: nxt.rdata[NPIN-1:0] = st.cfg.pd;
                A_STAT: nxt.rdata[7:0] = {st.cfg.stat_b, st.cfg.stat_a};
                A_GPIN: nxt.rdata[NGP-1:0] = st.pin_in;
                A_STATUS: nxt.rdata[5:0] = {st.otp_done, st.lvl_b,
                    st.lvl_a, i_usb.configured, i_usb.bus_reset,
                    i_usb.suspend};
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= ST_RST;
        end else if (i_ce) begin
            st <= nxt;
        end
    end

    assign o_rdata = st.rdata;
    assign o_pin_out = st.pin_out;
    assign o_pin_oe = st.pin_oe;
    assign o_pull_up = st.pull_up;
    assign o_pull_dn = st.pull_dn;
    assign o_cd_n = st.cd_n;
    assign o_cts_n = st.cts_n;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    a_cd_follow: assert property (i_ce && st.cfg.func[PIN_CD] // R1
        && i_resetn |=> o_cd_n == $past(st.pin_in[PIN_CD]))
        else $error("cd mismatch");
    a_stat_b_susp: assert property (i_ce && st.cfg.stat_b == 4'h2 // R2
        && i_usb.suspend && st.cfg.od[PIN_STB] |=> o_pin_oe[PIN_STB])
        else $error("status b not low in suspend");
    a_rx_toggle: assert property (i_ce && i_uart.rx_active // R3
        && st.cnt_rx == CNT_LAST |=> st.ind_rx != $past(st.ind_rx))
        else $error("rx indicator missed toggle");
    a_tx_toggle: assert property (i_ce && i_uart.tx_active // R4
        && st.cnt_tx == CNT_LAST |=> st.ind_tx != $past(st.ind_tx))
        else $error("tx indicator missed toggle");
    a_hd_enable: assert property (i_ce && st.cfg.func[PIN_HD] // R5
        && !st.cfg.od[PIN_HD] && i_resetn |=> o_pin_oe[PIN_HD]
        && o_pin_out[PIN_HD] == $past(i_uart.de))
        else $error("direction enable wrong");
    a_cts_follow: assert property (i_ce && st.cfg.func[PIN_CTS] // R6
        && i_resetn |=> o_cts_n == $past(st.pin_in[PIN_CTS])
        && !o_pin_oe[PIN_CTS]) else $error("cts mismatch");
    a_rts_od: assert property (i_ce && st.cfg.func[PIN_RTS] // R7
        && !st.cfg.rts485 && st.cfg.od[PIN_RTS] |=>
        o_pin_oe[PIN_RTS] == !$past(i_uart.rts_n))
        else $error("rts drive wrong");
    a_pd_write: assert property (i_ce && i_wr && i_addr == A_PD // R8
        && st.otp_done && !i_usb.bus_reset |=>
        st.cfg.pd == $past(i_wdata[NPIN-1:0]))
        else $error("pin type write lost");
    a_pull_hold: assert property (i_ce && !i_usb.bus_reset |=> // R9
        o_pull_up == $past(st.cfg.pu)) else $error("pull dropped");
    a_otp_once: assert property (st.otp_done |=> st.otp_done // R10
        && (st.base == $past(st.base) || !$past(i_ce)))
        else $error("otp base changed");
    a_bus_rst_pull: assert property (i_ce && i_usb.bus_reset |=> // R11
        o_pull_up == '0 && o_pull_dn == '0)
        else $error("pulls on in bus reset");
    a_bus_rst_cfg: assert property (i_ce && i_usb.bus_reset // R12
        && st.otp_done |=> st.cfg == $past(st.base))
        else $error("register settings kept");
    a_od_low: assert property (i_ce |=> // R13
        (o_pin_out & $past(st.cfg.od)) == '0) else $error("open drain high");
    a_pwr_cond: assert property (i_ce && st.cfg.stat_a[SC_PWR] // R14
        && st.cfg.stat_a[SC_POL] && i_usb.max_power > POWER_LIMIT
        && !i_usb.configured |=> st.lvl_a)
        else $error("power condition missed");
    a_idle_steady: assert property (i_ce && !i_uart.rx_active |=> // R15
        st.ind_rx) else $error("idle indicator not steady");

    c_rx_blink: cover property (i_ce && i_uart.rx_active
        && st.cnt_rx == CNT_LAST);
    c_bus_reset: cover property (i_ce && i_usb.bus_reset ##1 !i_usb.bus_reset);
    c_otp_load: cover property (!st.otp_done && i_otp_valid && i_ce);
    c_rts485: cover property (st.cfg.func[PIN_RTS] && st.cfg.rts485);

endmodule

// File: src/pin_cfg_pkg.sv
package pin_cfg_pkg;

    localparam int NGP = 6;
    localparam int NPIN = 8;
    localparam int PIN_RTS = 0;
    localparam int PIN_CTS = 1;
    localparam int PIN_HD = 2;
    localparam int PIN_TXT = 3;
    localparam int PIN_RXT = 4;
    localparam int PIN_CD = 5;
    localparam int PIN_STA = 6;
    localparam int PIN_STB = 7;

    localparam logic [7:0] A_FUNC = 8'h00;
    localparam logic [7:0] A_DIR = 8'h04;
    localparam logic [7:0] A_DOUT = 8'h08;
    localparam logic [7:0] A_OD = 8'h0C;
    localparam logic [7:0] A_PU = 8'h10;
    localparam logic [7:0] A_PD = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_GPIN = 8'h1C;
    localparam logic [7:0] A_STATUS = 8'h20;

    // Status condition select: bit 0 bus reset, 1 suspend, 2 power, 3 high.
    localparam int SC_RST = 0;
    localparam int SC_SUSP = 1;
    localparam int SC_PWR = 2;
    localparam int SC_POL = 3;
    localparam logic [7:0] POWER_LIMIT = 8'h32;

    localparam int TOGGLE_MS = 100;
    localparam int CLK_NS = 100;
    localparam int TOGGLE_CYC = TOGGLE_MS * 1000000 / CLK_NS;
    localparam int CNT_W = 20;

    typedef struct packed {
        logic       bus_reset;
        logic       suspend;
        logic       configured;
        logic [7:0] max_power;
    } usb_state_t;

    typedef struct packed {
        logic rts_n;
        logic de;
        logic rx_active;
        logic tx_active;
    } uart_side_t;

    typedef struct packed {
        logic [NGP-1:0]  func;
        logic            rts485;
        logic [NGP-1:0]  dir;
        logic [NGP-1:0]  dout;
        logic [NPIN-1:0] od;
        logic [NPIN-1:0] pu;
        logic [NPIN-1:0] pd;
        logic [3:0]      stat_a;
        logic [3:0]      stat_b;
    } cfg_t;

    localparam cfg_t CFG_DEF = '{
        func:   6'h1F,
        rts485: 1'b0,
        dir:    6'h00,
        dout:   6'h00,
        od:     8'hC1,
        pu:     8'h22,
        pd:     8'h00,
        stat_a: 4'hA,
        stat_b: 4'h2
    };

endpackage
